/* File: rtl/spi_format_pkg.sv */
// Constants shared by the serial format and flags register block.
package spi_format_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Register offsets on the plain register port.
  localparam logic [2:0] ADDR_FORMAT = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;
  // Field positions of the format and flags register.
  localparam int FMT_DONE = 0;
  localparam int FMT_COLL = 1;
  localparam int FMT_SEL_EN = 2;
  localparam int FMT_ORDER = 3;
  localparam int FMT_EDGE = 4;
  localparam int FMT_IDLE = 5;
  localparam int FMT_SPARE_LO = 6;
  localparam int FMT_SPARE_HI = 7;
  localparam logic [7:0] FMT_RESET = 8'h00;
  // Control register fields.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MASTER = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Interrupt status and mask fields.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_COLL = 1;
  localparam int IRQ_ABORT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Master serial clock half period.
  localparam int SYS_CLK_MHZ = 100;
  localparam int SCK_HALF_NS = 80;
  localparam logic [3:0] SCK_HALF_CYCLES = 4'((SCK_HALF_NS * SYS_CLK_MHZ) / 1000);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } engine_state_type;
endpackage

/* File: rtl/spi_format_ctrl.sv */
// Serial peripheral format, flags and byte shift engine with register port.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
//
// Contract
// R1: Bits 7 and 6 of the format register are plain software storage.
// R2: Idle level select 0 keeps the serial clock high between transfers.
// R3: Idle level select 1 keeps the serial clock low between transfers.
// R4: Idle level and edge select together choose the drive and sample edges.
// R5: Software sets idle level and edge before a transfer starts.
// R6: Edge select 0 samples on trailing edges, 1 on leading edges.
// R7: Shift order select chooses LSB or MSB first; both ends must match.
// R8: Data write during a transfer is ignored and sets the collision flag.
// R9: Byte completion sets the done flag, which raises an interrupt event.
// R10: Select pin enable low floats the select pin, high uses it.
module spi_format_ctrl (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  input wire logic select_n_in,
  output logic select_n_out,
  output logic select_oe_out
);
  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] shreg;
    logic [1:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    spi_format_pkg::engine_state_type state;
    logic [3:0] bitcnt;
    logic [3:0] divcnt;
    logic sck_level;
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    logic sel_meta;
    logic sel_sync;
    logic sdi_meta;
    logic sdi_sync;
    logic [7:0] rdata;
    logic irq;
    logic sck_drv;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
    logic sel_drv;
    logic sel_oe;
  } state_type;

  localparam state_type STATE_RESET = '{
    fmt: spi_format_pkg::FMT_RESET,
    shreg: 8'h00,
    ctrl: spi_format_pkg::CTRL_RESET,
    irq_stat: spi_format_pkg::IRQ_RESET,
    irq_mask: spi_format_pkg::IRQ_RESET,
    state: spi_format_pkg::ST_IDLE,
    bitcnt: 4'h0,
    divcnt: 4'h0,
    sck_level: 1'b1,
    sck_meta: 1'b0,
    sck_sync: 1'b0,
    sck_prev: 1'b0,
    sel_meta: 1'b1,
    sel_sync: 1'b1,
    sdi_meta: 1'b0,
    sdi_sync: 1'b0,
    rdata: 8'h00,
    irq: 1'b0,
    sck_drv: 1'b1,
    sck_oe: 1'b0,
    sdo: 1'b1,
    sdo_oe: 1'b0,
    sel_drv: 1'b1,
    sel_oe: 1'b0
  };

  state_type st;
  state_type nx;
  logic idle_level;
  logic master_en;
  logic slave_en;
  logic busy;
  logic edge_evt;
  logic edge_lead;
  logic sample_evt;
  logic data_wr;
  logic coll_evt;
  logic done_evt;
  logic abort_evt;

  always_comb begin
    nx = st;
    nx.sck_meta = sck_in;
    nx.sck_sync = st.sck_meta;
    nx.sck_prev = st.sck_sync;
    nx.sel_meta = select_n_in;
    nx.sel_sync = st.sel_meta;
    nx.sdi_meta = sdi_in;
    nx.sdi_sync = st.sdi_meta;
    idle_level = ~st.fmt[spi_format_pkg::FMT_IDLE]; // R2 R3
    master_en = st.ctrl[spi_format_pkg::CTRL_ENABLE] & st.ctrl[spi_format_pkg::CTRL_MASTER];
    slave_en = st.ctrl[spi_format_pkg::CTRL_ENABLE] & ~st.ctrl[spi_format_pkg::CTRL_MASTER];
    busy = (st.state == spi_format_pkg::ST_SHIFT);
    edge_evt = 1'b0;
    edge_lead = 1'b0;
    data_wr = wr_in && (addr_in == spi_format_pkg::ADDR_DATA);
    coll_evt = data_wr && busy;
    done_evt = 1'b0;
    abort_evt = 1'b0;

    // Clock edges: generated in master mode, found on the synced pin in slave mode.
    if (master_en && busy) begin
      if (st.divcnt == 4'h0) begin
        nx.divcnt = spi_format_pkg::SCK_HALF_CYCLES - 4'h1;
        nx.sck_level = ~st.sck_level;
        edge_evt = (st.bitcnt != spi_format_pkg::BITS_PER_BYTE);
        edge_lead = (st.sck_level == idle_level);
      end else begin
        nx.divcnt = st.divcnt - 4'h1;
      end
    end else if (slave_en && (~st.fmt[spi_format_pkg::FMT_SEL_EN] || ~st.sel_sync)) begin
      edge_evt = (st.sck_sync != st.sck_prev);
      edge_lead = (st.sck_sync != idle_level);
    end
    sample_evt = edge_evt && (edge_lead == st.fmt[spi_format_pkg::FMT_EDGE]); // R4 R6

    if (sample_evt) begin
      if (st.fmt[spi_format_pkg::FMT_ORDER]) begin
        nx.shreg = {st.shreg[6:0], st.sdi_sync}; // R7
      end else begin
        nx.shreg = {st.sdi_sync, st.shreg[7:1]}; // R7
      end
      nx.bitcnt = st.bitcnt + 4'h1;
      nx.state = spi_format_pkg::ST_SHIFT;
    end

    // A master ends once the clock is back at idle; a slave ends the cycle after its eighth sample.
    if (busy && (st.bitcnt == spi_format_pkg::BITS_PER_BYTE)
        && (!master_en || st.sck_level == idle_level)) begin
      done_evt = 1'b1;
    end
    if (slave_en && busy && st.fmt[spi_format_pkg::FMT_SEL_EN] && st.sel_sync
        && !done_evt) begin
      abort_evt = 1'b1;
    end
    if (done_evt || abort_evt) begin
      nx.state = spi_format_pkg::ST_IDLE;
      nx.bitcnt = 4'h0;
    end

    if (!busy) begin
      nx.sck_level = idle_level; // R2 R3
    end

    // Register writes.
    if (wr_in) begin
      unique case (addr_in)
        spi_format_pkg::ADDR_FORMAT: begin
          nx.fmt = wdata_in; // R1
        end
        spi_format_pkg::ADDR_DATA: begin
          if (!busy) begin // R8
            nx.shreg = wdata_in;
            if (master_en) begin
              nx.state = spi_format_pkg::ST_SHIFT;
              nx.bitcnt = 4'h0;
              nx.divcnt = spi_format_pkg::SCK_HALF_CYCLES - 4'h1;
              nx.sck_level = idle_level;
            end
          end
        end
        spi_format_pkg::ADDR_CTRL: begin
          nx.ctrl = wdata_in[1:0];
        end
        spi_format_pkg::ADDR_IRQ_MASK: begin
          nx.irq_mask = wdata_in[2:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads; status clears on read, and a new event wins over the clear.
    nx.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        spi_format_pkg::ADDR_FORMAT: nx.rdata = st.fmt;
        spi_format_pkg::ADDR_DATA: nx.rdata = st.shreg;
        spi_format_pkg::ADDR_CTRL: nx.rdata = {6'h00, st.ctrl};
        spi_format_pkg::ADDR_IRQ_STAT: begin
          nx.rdata = {5'h00, st.irq_stat};
          nx.irq_stat = 3'h0;
        end
        spi_format_pkg::ADDR_IRQ_MASK: nx.rdata = {5'h00, st.irq_mask};
        default: nx.rdata = 8'h00;
      endcase
    end
    if (coll_evt) begin
      nx.fmt[spi_format_pkg::FMT_COLL] = 1'b1; // R8
      nx.irq_stat[spi_format_pkg::IRQ_COLL] = 1'b1;
    end
    if (done_evt || abort_evt) begin
      nx.fmt[spi_format_pkg::FMT_DONE] = 1'b1; // R9
      nx.irq_stat[spi_format_pkg::IRQ_DONE] = 1'b1; // R9
    end
    if (abort_evt) begin
      nx.irq_stat[spi_format_pkg::IRQ_ABORT] = 1'b1;
    end
    nx.irq = |(nx.irq_stat & nx.irq_mask);

    // Pin drivers.
    nx.sck_drv = master_en ? nx.sck_level : idle_level; // R2 R3
    nx.sck_oe = master_en;
    // Data moves only on drive edges or while idle, so it never changes under the far end's sample edge.
    if (!busy || (edge_evt && !sample_evt)) begin // R4
      nx.sdo = nx.fmt[spi_format_pkg::FMT_ORDER] ? nx.shreg[7] : nx.shreg[0]; // R7
    end
    nx.sdo_oe = st.ctrl[spi_format_pkg::CTRL_ENABLE];
    nx.sel_drv = ~(master_en && nx.state == spi_format_pkg::ST_SHIFT);
    nx.sel_oe = master_en && st.fmt[spi_format_pkg::FMT_SEL_EN]; // R10
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= STATE_RESET;
    end else begin
      st <= nx;
    end
  end

  assign rdata_out = st.rdata;
  assign irq_out = st.irq;
  assign sck_out = st.sck_drv;
  assign sck_oe_out = st.sck_oe;
  assign sdo_out = st.sdo;
  assign sdo_oe_out = st.sdo_oe;
  assign select_n_out = st.sel_drv;
  assign select_oe_out = st.sel_oe;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_idle_high_clock: assert property ( // R2
    $past(st.state == spi_format_pkg::ST_IDLE) && $past(master_en)
    && !$past(st.fmt[spi_format_pkg::FMT_IDLE]) |-> sck_out
  ) else $error("serial clock not high while idle with select 0");

  chk_idle_low_clock: assert property ( // R3
    $past(st.state == spi_format_pkg::ST_IDLE) && $past(master_en)
    && $past(st.fmt[spi_format_pkg::FMT_IDLE]) |-> !sck_out
  ) else $error("serial clock not low while idle with select 1");

  chk_sample_edge_kind: assert property ( // R6
    master_en && sample_evt
    |=> (sck_out == !$past(st.fmt[spi_format_pkg::FMT_IDLE]))
        == !$past(st.fmt[spi_format_pkg::FMT_EDGE])
  ) else $error("sampled on the wrong clock edge");

  chk_sdo_sample_hold: assert property ( // R4
    master_en && sample_evt |=> $stable(sdo_out)
  ) else $error("serial data moved on a sample edge");

  chk_lsb_shift_dir: assert property ( // R7
    sample_evt && !st.fmt[spi_format_pkg::FMT_ORDER] && !wr_in
    |=> st.shreg[6:0] == $past(st.shreg[7:1])
  ) else $error("lsb first shift went the wrong way");

  chk_collision_flag: assert property ( // R8
    data_wr && busy |=> st.fmt[spi_format_pkg::FMT_COLL] && st.state != spi_format_pkg::ST_IDLE
      || st.fmt[spi_format_pkg::FMT_COLL] && st.fmt[spi_format_pkg::FMT_DONE]
  ) else $error("collision not flagged on write during transfer");

  chk_done_flag_set: assert property ( // R9
    st.state == spi_format_pkg::ST_SHIFT ##1 st.state == spi_format_pkg::ST_IDLE
    |-> st.fmt[spi_format_pkg::FMT_DONE]
  ) else $error("done flag not set at end of byte");

  chk_select_float: assert property ( // R10
    !st.fmt[spi_format_pkg::FMT_SEL_EN] |=> !st.sel_oe
  ) else $error("select pin driven while disabled");

  chk_spare_storage: assert property ( // R1
    wr_in && addr_in == spi_format_pkg::ADDR_FORMAT
    |=> st.fmt[7:6] == $past(wdata_in[7:6])
  ) else $error("spare bits did not store written value");

  chk_master_byte_len: assert property ( // R4
    master_en && !busy && data_wr |=> busy [*8]
  ) else $error("master transfer ended too early");

  cov_master_byte: cover property (
    master_en && data_wr && !busy ##[1:300] st.fmt[spi_format_pkg::FMT_DONE]
  );
  cov_collision: cover property (coll_evt);
  cov_slave_abort: cover property (abort_evt);
  cov_irq_raise: cover property (!st.irq ##1 st.irq);
endmodule

/* File: bench/spi_far_end.sv */
// Far end of the serial link: slave while the block is master, master otherwise.
`timescale 1ns/10ps
module spi_far_end (
  input wire logic sck_pin_in,
  input wire logic sdo_pin_in,
  input wire logic idle_sel_in,
  input wire logic edge_sel_in,
  input wire logic order_sel_in,
  output logic sdi_out,
  output logic sck_out,
  output logic select_n_out
);
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] rx_byte = 8'h00;
  int cnt = 8;
  initial begin
    sdi_out = 1'b0;
    sck_out = 1'b1;
    select_n_out = 1'b1;
  end
  function automatic int pos(input int i);
    return order_sel_in ? 7 - i : i;
  endfunction
  task automatic load(input logic [7:0] b);
    tx_byte = b;
    cnt = 0;
    sdi_out = b[pos(0)];
  endtask
  // Data moves on the drive edge, so it is steady across every sample edge.
  always @(sck_pin_in) begin
    if (cnt < 8) begin
      if (sck_pin_in === ~(idle_sel_in ^ edge_sel_in)) begin
        rx_byte[pos(cnt)] = sdo_pin_in;
        cnt = cnt + 1;
        if (cnt == 8) sdi_out <= #40 ~sdi_out;
      end else begin
        sdi_out = tx_byte[pos(cnt)];
      end
    end
  end
  task automatic run_master(input logic [7:0] b, input int n);
    sck_out = ~idle_sel_in;
    #5;
    load(b);
    select_n_out = 1'b0;
    #83;
    repeat (2 * n) begin
      sck_out = ~sck_out;
      #80;
    end
    select_n_out = 1'b1;
  endtask
endmodule

/* File: bench/spi_format_ctrl_tb_top.sv */
// Self-checking bench for the format, flags and shift block.
`timescale 1ns/10ps
module spi_format_ctrl_tb_top;
  localparam logic [2:0] A_FMT = spi_format_pkg::ADDR_FORMAT;
  localparam logic [2:0] A_DAT = spi_format_pkg::ADDR_DATA;
  localparam logic [2:0] A_ST = spi_format_pkg::ADDR_IRQ_STAT;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, fmt_m, tx, got;
  logic irq, sck_o, sck_oe, sdo, sdo_oe, sel_o, sel_oe, far_sdi, far_sck, far_sel;
  int fail_count = 0;
  int tests_run = 0;
  wire sck_w = sck_oe ? sck_o : far_sck;
  wire sdo_w = sdo_oe ? sdo : ~sdo;
  wire sel_w = sel_oe ? sel_o : far_sel;
  spi_format_ctrl uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
    .sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe), .sdi_in(far_sdi),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .select_n_in(sel_w), .select_n_out(sel_o),
    .select_oe_out(sel_oe));
  spi_far_end far (.sck_pin_in(sck_w), .sdo_pin_in(sdo_w), .idle_sel_in(fmt_m[5]),
    .edge_sel_in(fmt_m[4]), .order_sel_in(fmt_m[3]), .sdi_out(far_sdi),
    .sck_out(far_sck), .select_n_out(far_sel));
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_done();
    int i;
    got = 8'h00;
    for (i = 0; i < 150 && got[0] !== 1'b1; i++) rd_reg(A_FMT, got);
    if (got[0] !== 1'b1) begin
      fail_count++;
      $display("MISMATCH at %0t: transfer never completed", $time);
      final_report();
    end
  endtask
  initial begin
    int m;
    fmt_m = 8'h00;
    void'($urandom(45));
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd_reg(A_FMT, got);
    chk(got, spi_format_pkg::FMT_RESET);
    @(posedge sys_clk_in);
    #1 chk(rdata, 8'h00);
    chk({7'h00, sck_o}, 8'h01);
    for (m = 0; m < 4; m++) begin
      fmt_m = 8'($urandom) & 8'hfc;
      wr_reg(A_FMT, fmt_m);
      rd_reg(A_FMT, got);
      chk(got, fmt_m);
      chk({7'h00, sck_o}, {7'h00, ~fmt_m[5]});
    end
    $display("Test storage and idle level done");
    wr_reg(spi_format_pkg::ADDR_CTRL, 8'h03);
    for (m = 0; m < 8; m++) begin
      fmt_m = {2'(m), m[0], m[1], m[2], m[1] ^ m[2], 2'b00};
      wr_reg(A_FMT, fmt_m);
      wr_reg(spi_format_pkg::ADDR_IRQ_MASK, {7'h00, m[0]});
      tx = 8'($urandom);
      far.load(8'($urandom));
      chk({7'h00, sck_o}, {7'h00, ~fmt_m[5]});
      wr_reg(A_DAT, tx);
      wr_reg(A_DAT, ~tx);
      chk({7'h00, sel_oe}, {7'h00, fmt_m[2]});
      chk({7'h00, sel_o}, 8'h00);
      wait_done();
      chk(far.rx_byte, tx);
      rd_reg(A_DAT, got);
      chk(got, far.tx_byte);
      rd_reg(A_FMT, got);
      chk(got, fmt_m | 8'h03);
      chk({7'h00, irq}, {7'h00, m[0]});
      rd_reg(A_ST, got);
      chk(got, 8'h03);
      rd_reg(A_ST, got);
      chk(got, 8'h00);
      chk({7'h00, irq}, 8'h00);
      $display("Test master mode %0d done", m);
    end
    fmt_m = (8'($urandom) & 8'h38) | 8'h04;
    wr_reg(A_FMT, fmt_m);
    wr_reg(spi_format_pkg::ADDR_CTRL, 8'h01);
    tx = 8'($urandom);
    wr_reg(A_DAT, tx);
    far.run_master(8'($urandom), 8);
    wait_done();
    chk(far.rx_byte, tx);
    rd_reg(A_DAT, got);
    chk(got, far.tx_byte);
    rd_reg(A_ST, got);
    chk(got, 8'h01);
    far.run_master(8'h5a, 3);
    repeat (8) @(posedge sys_clk_in);
    rd_reg(A_ST, got);
    chk(got, 8'h05);
    $display("Test slave mode and abort done");
    final_report();
  end
endmodule
